// [src/cfg_defines.svh]
// Purpose: Offsets, fields, reset values and masks of the configuration block
// Assumes: Dword-indexed configuration offsets
// Notes:   Definitions only
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// Host ports of the address/data access mechanism
`define CFG_ADDR_PORT      16'h0cf8
`define CFG_DATA_PORT      16'h0cfc
`define CA_EN_BIT          31
`define CA_MASK            32'h80ff_fffc

// Function locations
`define BRIDGE_DEV         5'h1f
`define BRIDGE_FUNC        3'h0
`define IOAPIC_DEV         5'h00
`define IOAPIC_FUNC        3'h0
`define IOAPIC_BUS         8'h01

// Dword indices
`define OFS_ID             6'h00
`define OFS_CMD            6'h01
`define OFS_BUS            6'h06
`define OFS_MEM            6'h08
`define OFS_ONCE           6'h10
`define OFS_WO             6'h11

// Reset values
`define RST_CMDSTS         32'h00a0_0000
`define RST_BUS            32'h0000_0000
`define RST_MEM            32'h0000_0000
`define RST_ONCE           32'h0000_0000
`define RST_WO             32'h0000_0000

// Attribute masks
`define CMDSTS_RO          32'h06ff_fe00
`define CMDSTS_W1C         32'hf900_0000
`define APIC_CMD_RO        32'hffff_fff8

// Fields
`define CMD_MEM_EN_BIT     1
`define CMD_MASTER_EN_BIT  2
`define STS_MABORT_BIT     29
`define STS_SERR_BIT       30
`define MEM_BASE_LSB       4
`define MEM_LIM_LSB        20

`endif

// [src/cfg_pkg.sv]
// Purpose: Shared types of the configuration block
// Assumes: Nothing
// Notes:   Constants live in cfg_defines.svh
package cfg_pkg;
	typedef logic [31:0] dword_t;
	typedef enum logic [1:0] {
		TGT_NONE   = 2'b00,
		TGT_BRIDGE = 2'b01,
		TGT_IOAPIC = 2'b10
	} target_e;
endpackage : cfg_pkg

// [src/cfg_field.sv]
// Purpose: One 32-bit configuration register with per-bit access attributes
// Assumes: Byte enables already expanded into wmask
// Notes:   Write-once tracking survives rstn, cleared by por_n only
module cfg_field #(
	parameter logic [31:0] RESET     = 32'h0,
	parameter logic [31:0] RO_MASK   = 32'h0,
	parameter logic [31:0] W1C_MASK  = 32'h0,
	parameter logic [31:0] ONCE_MASK = 32'h0
) (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        por_n,
	// Write side
	input  wire logic        we,
	input  wire logic [31:0] wmask,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] set,
	// Stored value
	output logic      [31:0] value
);
	logic [31:0] once_done;

	for (genvar b = 0; b < 32; b++)
	begin : g_bit
		always_ff @(posedge clk or negedge por_n)
		begin
			if (!por_n)
				once_done[b] <= 1'b0;
			else if (ONCE_MASK[b] && we && wmask[b])
				once_done[b] <= 1'b1;
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				value[b] <= RESET[b];
			else if (set[b])
				value[b] <= 1'b1;
			else if (we && wmask[b] && !RO_MASK[b])
			begin
				if (W1C_MASK[b])
				begin
					if (wdata[b])
						value[b] <= 1'b0;
				end
				else if (!ONCE_MASK[b] || !once_done[b])
					value[b] <= wdata[b];
			end
		end
	end

	a_ro_bits_hold: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> ((value & RO_MASK) == (RESET & RO_MASK)))
		else $error("read-only bit changed");
	a_w1c_clears: assert property (@(posedge clk) disable iff (!rstn)
		(we && |(wmask & wdata & W1C_MASK & ~set))
		|=> ((value & $past(wmask & wdata & W1C_MASK & ~set)) == 32'h0))
		else $error("write-one-clear bit not cleared");
	a_once_locks: assert property (@(posedge clk) disable iff (!rstn || !por_n)
		(|(once_done & ONCE_MASK) && !(|set))
		|=> ((value & $past(once_done & ONCE_MASK)) ==
		($past(value) & $past(once_done & ONCE_MASK))))
		else $error("write-once bit took a second write");
endmodule : cfg_field

// [src/sec_bus_arbiter.sv]
// Purpose: Round-robin grant of the secondary bus among its masters
// Assumes: Requests already synchronised to clk
// Notes:   A grant stays while its request stays and enable stays high
module sec_bus_arbiter #(
	parameter int MASTERS = 6
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Control
	input  wire logic               enable,
	// Requests and grants
	input  wire logic [MASTERS-1:0] req,
	output logic      [MASTERS-1:0] gnt
);
	localparam int LW = $clog2(MASTERS);

	if (MASTERS < 2 || MASTERS > 8)
	begin : g_bad_masters
		$error("sec_bus_arbiter: MASTERS must be 2..8");
	end

	logic [MASTERS-1:0] next_gnt;
	logic [LW-1:0]      last;

	always_comb
	begin
		int idx;
		idx = 0;
		next_gnt = '0;
		if (enable)
		begin
			if (|(gnt & req))
				next_gnt = gnt;
			else
				for (int k = 1; k <= MASTERS; k++)
				begin
					idx = (int'(last) + k) % MASTERS;
					if (next_gnt == '0 && req[idx])
						next_gnt[idx] = 1'b1;
				end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			gnt <= '0;
		else
			gnt <= next_gnt;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			last <= '0;
		else
			for (int k = 0; k < MASTERS; k++)
				if (next_gnt[k])
					last <= LW'(k);
	end

	a_gnt_onehot: assert property (@(posedge clk) disable iff (!rstn)
		$onehot0(gnt))
		else $error("more than one grant");
	a_gnt_needs_req: assert property (@(posedge clk) disable iff (!rstn)
		|gnt |-> $past(enable) && (($past(req) & gnt) != '0))
		else $error("grant without request");
	c_grant_switch: cover property (@(posedge clk) disable iff (!rstn)
		(|gnt) ##1 (|gnt && gnt != $past(gnt)));
endmodule : sec_bus_arbiter

// [src/bridge_config_space_access.sv]
// Purpose: Configuration space of the bridge and the interrupt controller
// Assumes: Host accesses arrive on clk as single-cycle requests
// Notes:   One answer per request, one cycle later
`include "cfg_defines.svh"

module bridge_config_space_access #(
	parameter logic [15:0] VENDOR_ID   = 16'h1234, // Arbitrary value
	parameter logic [15:0] BRIDGE_ID   = 16'h0001, // Arbitrary value
	parameter logic [15:0] IOAPIC_ID   = 16'h0002, // Arbitrary value
	parameter int          MASTERS     = 6
) (
	// Clock and resets
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               por_n,
	// Host access port
	input  wire logic               io_req,
	input  wire logic               io_write,
	input  wire logic [15:0]        io_addr,
	input  wire logic [3:0]         io_be,
	input  wire logic [31:0]        io_wdata,
	output logic                    io_ack,
	output logic      [31:0]        io_rdata,
	// Status events
	input  wire logic               status_set_serr,
	input  wire logic               status_set_mabort,
	// Secondary bus arbitration
	input  wire logic [MASTERS-1:0] sec_req_pin,
	output logic      [MASTERS-1:0] sec_gnt,
	// Upstream forward decode
	input  wire logic               hub_addr_valid,
	input  wire logic [31:0]        hub_addr,
	output logic                    fwd_valid,
	output logic                    fwd_hit,
	// Configuration outputs
	output logic      [7:0]         sec_bus_num,
	output logic      [7:0]         sub_bus_num,
	output logic      [5:0]         pclk_off,
	output logic      [7:0]         apic_id
);
	cfg_pkg::dword_t  cfg_addr;
	cfg_pkg::dword_t  cmdsts;
	cfg_pkg::dword_t  busnum;
	cfg_pkg::dword_t  memwin;
	cfg_pkg::dword_t  b_once;
	cfg_pkg::dword_t  b_wo;
	cfg_pkg::dword_t  a_cmd;
	cfg_pkg::dword_t  a_once;
	cfg_pkg::dword_t  wmask;
	cfg_pkg::dword_t  sts_set;
	cfg_pkg::dword_t  next_rdata;
	cfg_pkg::target_e tgt;
	logic             data_acc;
	logic             wr_acc;
	logic [5:0]       ca_idx;
	logic [MASTERS-1:0] req_meta;
	logic [MASTERS-1:0] req_sync;
	logic [31:0]      dummy_w;

	// Arbiter serves two to eight masters
	if (MASTERS < 2 || MASTERS > 8)
	begin : g_bad_masters
		$error("bridge_config_space_access: MASTERS must be 2..8");
	end

	// Address register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cfg_addr <= 32'h0;
		else if (io_req && io_write && io_addr == `CFG_ADDR_PORT && io_be == 4'hf)
			cfg_addr <= io_wdata & `CA_MASK;
	end

	// Function decode
	assign ca_idx   = cfg_addr[7:2];
	assign data_acc = io_req && io_addr == `CFG_DATA_PORT && cfg_addr[`CA_EN_BIT];
	assign wr_acc   = data_acc && io_write;
	assign wmask    = {{8{io_be[3]}}, {8{io_be[2]}}, {8{io_be[1]}}, {8{io_be[0]}}};

	always_comb
	begin
		tgt = cfg_pkg::TGT_NONE;
		if (cfg_addr[23:16] == busnum[7:0] && cfg_addr[15:11] == `BRIDGE_DEV
			&& cfg_addr[10:8] == `BRIDGE_FUNC)
			tgt = cfg_pkg::TGT_BRIDGE;
		else if (cfg_addr[23:16] == `IOAPIC_BUS && cfg_addr[15:11] == `IOAPIC_DEV
			&& cfg_addr[10:8] == `IOAPIC_FUNC)
			tgt = cfg_pkg::TGT_IOAPIC;
	end

	always_comb
	begin
		sts_set = 32'h0;
		sts_set[`STS_SERR_BIT] = status_set_serr;
		sts_set[`STS_MABORT_BIT] = status_set_mabort;
	end

	assign dummy_w = 32'h0;

	// Bridge registers
	cfg_field #(.RESET(`RST_CMDSTS), .RO_MASK(`CMDSTS_RO), .W1C_MASK(`CMDSTS_W1C)) u_cmdsts (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_CMD),
		.wmask(wmask), .wdata(io_wdata), .set(sts_set), .value(cmdsts));
	cfg_field #(.RESET(`RST_BUS)) u_busnum (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_BUS),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(busnum));
	cfg_field #(.RESET(`RST_MEM)) u_memwin (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_MEM),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(memwin));
	cfg_field #(.RESET(`RST_ONCE), .ONCE_MASK(32'hffff_ffff)) u_b_once (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_ONCE),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(b_once));
	cfg_field #(.RESET(`RST_WO)) u_b_wo (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_WO),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(b_wo));

	// Interrupt controller registers
	cfg_field #(.RESET(32'h0), .RO_MASK(`APIC_CMD_RO)) u_a_cmd (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_IOAPIC && ca_idx == `OFS_CMD),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(a_cmd));
	cfg_field #(.RESET(`RST_ONCE), .ONCE_MASK(32'h0000_00ff), .RO_MASK(32'hffff_ff00)) u_a_once (
		.clk(clk), .rstn(rstn), .por_n(por_n),
		.we(wr_acc && tgt == cfg_pkg::TGT_IOAPIC && ca_idx == `OFS_ONCE),
		.wmask(wmask), .wdata(io_wdata), .set(dummy_w), .value(a_once));

	// Read data
	always_comb
	begin
		next_rdata = 32'h0;
		if (io_addr == `CFG_ADDR_PORT)
			next_rdata = cfg_addr;
		else if (data_acc)
			unique case (tgt)
				cfg_pkg::TGT_BRIDGE:
					unique case (ca_idx)
						`OFS_ID:   next_rdata = {BRIDGE_ID, VENDOR_ID};
						`OFS_CMD:  next_rdata = cmdsts;
						`OFS_BUS:  next_rdata = busnum;
						`OFS_MEM:  next_rdata = memwin;
						`OFS_ONCE: next_rdata = b_once;
						default:   next_rdata = 32'h0;
					endcase
				cfg_pkg::TGT_IOAPIC:
					unique case (ca_idx)
						`OFS_ID:   next_rdata = {IOAPIC_ID, VENDOR_ID};
						`OFS_CMD:  next_rdata = a_cmd;
						`OFS_ONCE: next_rdata = a_once;
						default:   next_rdata = 32'h0;
					endcase
				cfg_pkg::TGT_NONE:
					next_rdata = 32'h0;
			endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			io_ack   <= 1'b0;
			io_rdata <= 32'h0;
		end
		else
		begin
			io_ack   <= io_req;
			io_rdata <= (io_req && !io_write) ? next_rdata : 32'h0;
		end
	end

	// Secondary bus arbitration
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			req_meta <= '0;
			req_sync <= '0;
		end
		else
		begin
			req_meta <= sec_req_pin;
			req_sync <= req_meta;
		end
	end

	sec_bus_arbiter #(.MASTERS(MASTERS)) u_arb (
		.clk(clk), .rstn(rstn),
		.enable(cmdsts[`CMD_MASTER_EN_BIT]),
		.req(req_sync), .gnt(sec_gnt));

	// Upstream forward decode
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fwd_valid <= 1'b0;
			fwd_hit   <= 1'b0;
		end
		else
		begin
			fwd_valid <= hub_addr_valid;
			fwd_hit   <= hub_addr_valid && cmdsts[`CMD_MEM_EN_BIT]
				&& hub_addr[31:20] >= memwin[`MEM_BASE_LSB +: 12]
				&& hub_addr[31:20] <= memwin[`MEM_LIM_LSB +: 12];
		end
	end

	// Configuration outputs
	assign sec_bus_num = busnum[15:8];
	assign sub_bus_num = busnum[23:16];
	assign pclk_off    = b_wo[5:0];
	assign apic_id     = a_once[7:0];

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_ack_follows: assert property (io_req |=> io_ack ##1 !io_ack || $past(io_req))
		else $error("answer not one cycle after request");
	a_addr_masked: assert property ((cfg_addr & ~`CA_MASK) == 32'h0)
		else $error("address register holds reserved bits");
	a_bridge_id: assert property (io_req && !io_write && data_acc
		&& tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_ID
		|=> io_rdata == {BRIDGE_ID, VENDOR_ID})
		else $error("bridge identity read wrong");
	a_ioapic_bus: assert property (tgt == cfg_pkg::TGT_IOAPIC
		|-> cfg_addr[23:16] == `IOAPIC_BUS)
		else $error("controller decoded off bus 1");
	a_fwd_decode: assert property (hub_addr_valid && !cmdsts[`CMD_MEM_EN_BIT]
		|=> fwd_valid && !fwd_hit)
		else $error("forward hit while decode disabled");
	a_reset_default: assert property ($rose(rstn) |-> busnum == `RST_BUS
		&& cmdsts == `RST_CMDSTS && cfg_addr == 32'h0)
		else $error("defaults not loaded at reset");
	a_rw_store: assert property (wr_acc && tgt == cfg_pkg::TGT_BRIDGE
		&& ca_idx == `OFS_BUS && io_be == 4'hf
		|=> busnum == $past(io_wdata))
		else $error("read/write register did not store");
	a_rw_readback: assert property (io_req && !io_write && data_acc
		&& tgt == cfg_pkg::TGT_BRIDGE && ca_idx == `OFS_BUS
		|=> io_rdata == $past(busnum))
		else $error("read/write register readback wrong");
	a_unclaimed_write: assert property (wr_acc && tgt == cfg_pkg::TGT_NONE
		|=> $stable(busnum) && $stable(memwin))
		else $error("unclaimed write changed a register");
	a_disabled_data: assert property (io_req && !io_write
		&& io_addr == `CFG_DATA_PORT && !cfg_addr[`CA_EN_BIT]
		|=> io_rdata == 32'h0)
		else $error("disabled data port returned data");
	a_rdata_idle: assert property (!io_req |=> io_rdata == 32'h0)
		else $error("read data outside an answer");
	a_apic_cmd_ro: assert property ((a_cmd & `APIC_CMD_RO) == 32'h0)
		else $error("controller read-only bits changed");
	a_set_wins: assert property (status_set_serr |=> cmdsts[`STS_SERR_BIT])
		else $error("status event not recorded");
	a_gnt_enable: assert property (!cmdsts[`CMD_MASTER_EN_BIT] |=> sec_gnt == '0)
		else $error("grant while arbitration disabled");
	a_fwd_window: assert property (fwd_hit |-> $past(cmdsts[`CMD_MEM_EN_BIT])
		&& $past(hub_addr[31:20]) >= $past(memwin[`MEM_BASE_LSB +: 12])
		&& $past(hub_addr[31:20]) <= $past(memwin[`MEM_LIM_LSB +: 12]))
		else $error("forward hit outside window");
	a_reserved_read: assert property (io_req && !io_write && data_acc
		&& tgt == cfg_pkg::TGT_NONE |=> io_rdata == 32'h0)
		else $error("unclaimed read not zero");

	c_once_write: cover property (wr_acc && tgt == cfg_pkg::TGT_IOAPIC
		&& ca_idx == `OFS_ONCE);
	c_status_clear: cover property (wr_acc && ca_idx == `OFS_CMD
		&& io_wdata[`STS_SERR_BIT] && cmdsts[`STS_SERR_BIT]);
	c_fwd_hit: cover property (fwd_hit);
	c_gnt_given: cover property (|sec_gnt);
endmodule : bridge_config_space_access

// [testbench/cfg_host_model.sv]
// Purpose: Host software model issuing configuration accesses
// Assumes: One answer per request, one cycle after it
// Notes:   Drives on the rising edge by non-blocking assignment
`include "cfg_defines.svh"

module cfg_host_model (
	// Clock
	input	wire logic		clk,
	// Host access port
	output	logic			io_req,
	output	logic			io_write,
	output	logic	[15:0]	io_addr,
	output	logic	[3:0]	io_be,
	output	logic	[31:0]	io_wdata,
	input	wire logic		io_ack,
	input	wire logic	[31:0]	io_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		io_req = 1'b0;
		io_write = 1'b0;
		io_addr = 16'h0000;
		io_be = 4'hf;
		io_wdata = 32'h0000_0000;
	end

	// One port access
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic k);
		@(posedge clk);
		io_req <= 1'b1;
		io_write <= w;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clk);
		io_req <= 1'b0;
		#1;
		r = io_rdata;
		k = io_ack;
	endtask : acc

	// Address register, then data port
	task cfg(input logic [7:0] b, input logic [4:0] dv, input logic [5:0] x,
		input logic w, input logic [31:0] d, output logic [31:0] r, output logic k);
		logic [31:0] t;
		logic k1;
		acc(1'b1, `CFG_ADDR_PORT, {1'b1, 7'h00, b, dv, 3'h0, x, 2'h0}, t, k1);
		acc(w, `CFG_DATA_PORT, d, r, k);
		k = k & k1;
	endtask : cfg

	// Read, merge, write back
	task rmw(input logic [7:0] b, input logic [4:0] dv, input logic [5:0] x,
		input logic [31:0] m, input logic [31:0] v, output logic [31:0] r, output logic k);
		logic [31:0] t;
		logic k1;
		cfg(b, dv, x, 1'b0, 32'h0000_0000, t, k1);
		cfg(b, dv, x, 1'b1, (t & ~m) | (v & m), r, k);
		r = t & m;
		k = k & k1;
	endtask : rmw
endmodule : cfg_host_model

// [testbench/bridge_config_space_access_tb_top.sv]
// Purpose: Self-checking bench of the configuration block
// Assumes: Host model drives the access port
// Notes:   Reset default read first, then table rows, then hand-written cases
`include "cfg_defines.svh"

module bridge_config_space_access_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] VEND_ID = 16'h1234; // Arbitrary value
	localparam logic [15:0] BRG_ID = 16'h0001; // Arbitrary value
	localparam logic [15:0] APIC_ID = 16'h0002; // Arbitrary value

	typedef struct packed {
		logic [7:0]	b;
		logic [4:0]	d;
		logic [5:0]	x;
		logic [31:0]	w;
		logic [31:0]	e;
	} row_s;

	localparam row_s ROWS [6] = '{
		'{8'h00, 5'h1f, 6'h06, 32'h0003_0200, 32'h0003_0200},
		'{8'h00, 5'h1f, 6'h08, 32'h0200_0100, 32'h0200_0100},
		'{8'h00, 5'h1f, 6'h00, 32'hffff_ffff, {BRG_ID, VEND_ID}},
		'{8'h01, 5'h00, 6'h00, 32'hffff_ffff, {APIC_ID, VEND_ID}},
		'{8'h01, 5'h00, 6'h01, 32'hffff_ffff, 32'h0000_0007},
		'{8'h00, 5'h00, 6'h01, 32'hffff_ffff, 32'h0000_0000}
	};

	logic		clk, rstn, por_n, io_req, io_write, io_ack;
	logic	[15:0]	io_addr;
	logic	[3:0]	io_be;
	logic	[31:0]	io_wdata, io_rdata, hub_addr, rd;
	logic		status_set_serr, status_set_mabort, hub_addr_valid;
	logic		fwd_valid, fwd_hit, ok;
	logic	[5:0]	sec_req_pin, sec_gnt, pclk_off;
	logic	[7:0]	sec_bus_num, sub_bus_num, apic_id;
	int		fails, total_checks, n;

	bridge_config_space_access #(.VENDOR_ID(VEND_ID), .BRIDGE_ID(BRG_ID),
		.IOAPIC_ID(APIC_ID), .MASTERS(6)) u_dut (.clk(clk), .rstn(rstn),
		.por_n(por_n), .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
		.io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata),
		.status_set_serr(status_set_serr), .status_set_mabort(status_set_mabort),
		.sec_req_pin(sec_req_pin), .sec_gnt(sec_gnt), .hub_addr_valid(hub_addr_valid),
		.hub_addr(hub_addr), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit),
		.sec_bus_num(sec_bus_num), .sub_bus_num(sub_bus_num), .pclk_off(pclk_off),
		.apic_id(apic_id));

	cfg_host_model u_host (.clk(clk), .io_req(io_req), .io_write(io_write),
		.io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack),
		.io_rdata(io_rdata));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			fails++;
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// One configuration access, answer checked
	task op(input logic [7:0] b, input logic [4:0] d, input logic [5:0] x,
		input logic w, input logic [31:0] v);
		u_host.cfg(b, d, x, w, v, rd, ok);
		chk("io_ack", {31'h0, ok}, 32'h0000_0001);
	endtask : op

	// Write, read back, compare
	task wrd(input logic [7:0] b, input logic [4:0] d, input logic [5:0] x,
		input logic [31:0] v, input logic [31:0] e);
		op(b, d, x, 1'b1, v);
		op(b, d, x, 1'b0, 32'h0000_0000);
		chk("readback", rd, e);
	endtask : wrd

	task fwd(input logic [31:0] a, input logic e);
		@(posedge clk);
		hub_addr_valid <= 1'b1;
		hub_addr <= a;
		@(posedge clk);
		hub_addr_valid <= 1'b0;
		#1;
		chk("fwd_valid", {31'h0, fwd_valid}, 32'h0000_0001);
		chk("fwd_hit", {31'h0, fwd_hit}, {31'h0, e});
	endtask : fwd

	initial
	begin
		rstn = 1'b0;
		por_n = 1'b0;
		status_set_serr = 1'b0;
		status_set_mabort = 1'b0;
		sec_req_pin = 6'h00;
		hub_addr_valid = 1'b0;
		hub_addr = 32'h0000_0000;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		por_n <= 1'b1;
		op(8'h00, 5'h1f, 6'h01, 1'b0, 32'h0000_0000);
		chk("cmdsts default", rd, `RST_CMDSTS);
		foreach (ROWS[i])
			wrd(ROWS[i].b, ROWS[i].d, ROWS[i].x, ROWS[i].w, ROWS[i].e);
		chk("sec_bus_num", {24'h0, sec_bus_num}, 32'h0000_0002);
		chk("sub_bus_num", {24'h0, sub_bus_num}, 32'h0000_0003);
		u_host.acc(1'b1, `CFG_ADDR_PORT, 32'h0000_0018, rd, ok);
		u_host.acc(1'b0, `CFG_DATA_PORT, 32'h0000_0000, rd, ok);
		chk("disabled data", rd, 32'h0000_0000);
		u_host.acc(1'b1, `CFG_ADDR_PORT, 32'hffff_ffff, rd, ok);
		u_host.acc(1'b0, `CFG_ADDR_PORT, 32'h0000_0000, rd, ok);
		chk("addr reg", rd, `CA_MASK);
		fwd(32'h0180_0000, 1'b0);
		sec_req_pin <= 6'h01;
		repeat (6) @(posedge clk);
		chk("gnt off", {26'h0, sec_gnt}, 32'h0000_0000);
		u_host.rmw(8'h00, 5'h1f, 6'h01, 32'h0000_0006, 32'h0000_0006, rd, ok);
		chk("rmw old", rd, 32'h0000_0000);
		n = 0;
		while (sec_gnt !== 6'h01 && n < 8)
		begin
			@(posedge clk);
			n++;
		end
		chk("gnt on", {26'h0, sec_gnt}, 32'h0000_0001);
		sec_req_pin <= 6'h00;
		fwd(32'h0180_0000, 1'b1);
		fwd(32'h0300_0000, 1'b0);
		@(posedge clk);
		status_set_serr <= 1'b1;
		status_set_mabort <= 1'b1;
		@(posedge clk);
		status_set_serr <= 1'b0;
		status_set_mabort <= 1'b0;
		wrd(8'h00, 5'h1f, 6'h01, 32'h0000_0006, 32'h60a0_0006);
		wrd(8'h00, 5'h1f, 6'h01, 32'h4000_0006, 32'h20a0_0006);
		wrd(8'h00, 5'h1f, 6'h01, 32'h2000_0006, 32'h00a0_0006);
		wrd(8'h00, 5'h1f, 6'h10, 32'ha5a5_0001, 32'ha5a5_0001);
		wrd(8'h00, 5'h1f, 6'h10, 32'h0000_ffff, 32'ha5a5_0001);
		op(8'h01, 5'h00, 6'h10, 1'b1, 32'h0000_005a);
		chk("apic_id", {24'h0, apic_id}, 32'h0000_005a);
		op(8'h00, 5'h1f, 6'h11, 1'b1, 32'h0000_003f);
		chk("pclk_off", {26'h0, pclk_off}, 32'h0000_003f);
		op(8'h00, 5'h1f, 6'h11, 1'b0, 32'h0000_0000);
		op(8'h00, 5'h1f, 6'h02, 1'b0, 32'h0000_0000);
		@(posedge clk);
		#2;
		rstn = 1'b0;
		#1;
		chk("async bus", {24'h0, sec_bus_num}, 32'h0000_0000);
		chk("async id", {24'h0, apic_id}, 32'h0000_0000);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		op(8'h00, 5'h1f, 6'h06, 1'b0, 32'h0000_0000);
		chk("bus default", rd, `RST_BUS);
		wrd(8'h00, 5'h1f, 6'h10, 32'h1111_1111, 32'h0000_0000);
		@(posedge clk);
		rstn <= 1'b0;
		por_n <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		por_n <= 1'b1;
		wrd(8'h00, 5'h1f, 6'h10, 32'h1111_1111, 32'h1111_1111);
		close_out();
	end
endmodule : bridge_config_space_access_tb_top
